/* rtl/pga_pkg.sv */
// pga_pkg: constants, encodings and carriers for the password access gate.
// assumes: table numbers and byte offsets are 8-bit values as seen by the
// serial management engine that sits in front of the gate.
package pga_pkg;

   // ************************************************************
   // privilege and memory regions
   // ************************************************************
   typedef enum logic [1:0] {PGA_LVL_NONE, PGA_LVL_ONE, PGA_LVL_TWO} pga_level_t;
   typedef enum logic [0:0] {PGA_RGN_MAIN, PGA_RGN_AUX} pga_region_t;

   typedef struct packed {
      logic        write;
      pga_region_t region;
      logic [7:0]  table_num;
      logic [7:0]  addr;
   } pga_req_t;

   typedef struct packed {
      logic       readOk;
      logic       writeOk;
   } pga_verdict_t;

   // ************************************************************
   // register map of the register port
   // ************************************************************
   localparam logic [7:0] PGA_OFF_PERM_A   = 8'hC0;
   localparam logic [7:0] PGA_OFF_PERM_B   = 8'hC1;
   localparam logic [7:0] PGA_OFF_STATUS   = 8'hD0;
   localparam logic [7:0] PGA_OFF_DEN_RD   = 8'hD1;
   localparam logic [7:0] PGA_OFF_DEN_WR   = 8'hD2;
   localparam logic [7:0] PGA_OFF_LAST_ADR = 8'hD3;
   localparam logic [7:0] PGA_OFF_LAST_TBL = 8'hD4;
   localparam logic [7:0] PGA_RST_PERM_A   = 8'h10;
   localparam logic [7:0] PGA_RST_PERM_B   = 8'h03;
   localparam logic [7:0] PGA_ZERO_BYTE    = 8'h00;
   localparam logic [7:0] PGA_FULL_BYTE    = 8'hFF;

   // first permission register fields
   localparam int PGA_A_TBL78   = 7;
   localparam int PGA_A_T1TOP   = 6;
   localparam int PGA_A_CFG     = 5;
   localparam int PGA_A_T1LOW   = 4;
   localparam int PGA_A_T1MID   = 3;
   localparam int PGA_A_LOWER   = 2;
   localparam int PGA_A_AUXLO   = 1;
   localparam int PGA_A_AUXHI   = 0;
   // second permission register fields
   localparam int PGA_B_TBL46   = 7;
   localparam int PGA_B_T1TOP   = 6;
   localparam int PGA_B_CFG     = 5;
   localparam int PGA_B_T1LOW   = 4;
   localparam int PGA_B_T1MID   = 3;
   localparam int PGA_B_KEY1    = 2;
   localparam int PGA_B_AUXLO   = 1;
   localparam int PGA_B_AUXHI   = 0;

   // ************************************************************
   // table numbers and address bounds
   // ************************************************************
   localparam logic [7:0] PGA_TBL_01       = 8'h01;
   localparam logic [7:0] PGA_TBL_CFG      = 8'h02;
   localparam logic [7:0] PGA_TBL_04       = 8'h04;
   localparam logic [7:0] PGA_TBL_05       = 8'h05;
   localparam logic [7:0] PGA_TBL_06       = 8'h06;
   localparam logic [7:0] PGA_TBL_07       = 8'h07;
   localparam logic [7:0] PGA_TBL_08       = 8'h08;
   localparam logic [7:0] PGA_LOWER_END    = 8'h5F;
   localparam logic [7:0] PGA_UPPER_BASE   = 8'h80;
   localparam logic [7:0] PGA_T1LOW_END    = 8'hBF;
   localparam logic [7:0] PGA_T1MID_END    = 8'hF7;
   localparam logic [7:0] PGA_KEY1_BASE    = 8'hB0;
   localparam logic [7:0] PGA_KEY1_END     = 8'hB3;

endpackage

/* rtl/pga_decide.sv */
// pga_decide: purely combinational read and write verdict for one access.
// assumes: the caller registers the verdict; the level comes from a password
// comparison done elsewhere.
`timescale 1ns/1ps
`default_nettype none
module pga_decide (
   input  wire logic [7:0]          permA,
   input  wire logic [7:0]          permB,
   input  wire pga_pkg::pga_level_t level,
   input  wire logic                tableMask,
   input  wire pga_pkg::pga_req_t   req,
   output pga_pkg::pga_verdict_t    verdict
);
   // ************************************************************
   // who is asking and where
   // ************************************************************
   wire lvl2 = (level == pga_pkg::PGA_LVL_TWO);
   wire lvl1 = (level == pga_pkg::PGA_LVL_ONE) | lvl2;
   wire inAux = (req.region == pga_pkg::PGA_RGN_AUX);
   wire auxHigh = (req.addr >= pga_pkg::PGA_UPPER_BASE);
   wire inLower = ~inAux & (req.addr <= pga_pkg::PGA_LOWER_END);
   wire inTable = ~inAux & (req.addr >= pga_pkg::PGA_UPPER_BASE);
   wire [7:0] tbl = req.table_num;
   // mask low picks table 01h for the top bytes, mask high picks 05h
   wire [7:0] topTbl = tableMask ? pga_pkg::PGA_TBL_05 : pga_pkg::PGA_TBL_01;
   wire inTop = inTable & (tbl == topTbl) & (req.addr > pga_pkg::PGA_T1MID_END);
   wire inT1Low = inTable & (tbl == pga_pkg::PGA_TBL_01) & (req.addr <= pga_pkg::PGA_T1LOW_END);
   wire inT1Mid = inTable & (tbl == pga_pkg::PGA_TBL_01) & (req.addr > pga_pkg::PGA_T1LOW_END)
                  & (req.addr <= pga_pkg::PGA_T1MID_END);
   wire inCfg = inTable & (tbl == pga_pkg::PGA_TBL_CFG);
   wire inKey1 = inCfg & (req.addr >= pga_pkg::PGA_KEY1_BASE) & (req.addr <= pga_pkg::PGA_KEY1_END);
   wire inT46 = inTable & ((tbl == pga_pkg::PGA_TBL_04) | (tbl == pga_pkg::PGA_TBL_06));
   wire inT78 = inTable & ((tbl == pga_pkg::PGA_TBL_07) | (tbl == pga_pkg::PGA_TBL_08));

   // ************************************************************
   // per-region grants
   // ************************************************************
   wire cfgRd = lvl2 | (lvl1 & (permA[pga_pkg::PGA_A_CFG] | permB[pga_pkg::PGA_B_CFG]));
   wire cfgWr = lvl2 | (lvl1 & permA[pga_pkg::PGA_A_CFG]);
   wire keyWr = lvl2 | (lvl1 & permB[pga_pkg::PGA_B_KEY1]);
   wire t78   = lvl2 | (lvl1 & permA[pga_pkg::PGA_A_TBL78]);
   wire t46   = lvl2 | (lvl1 & permB[pga_pkg::PGA_B_TBL46]);
   wire topWr = lvl2 | (lvl1 & permA[pga_pkg::PGA_A_T1TOP]);
   wire topRd = topWr | (lvl1 & permB[pga_pkg::PGA_B_T1TOP]);
   wire lowWr = lvl2 | (lvl1 & permA[pga_pkg::PGA_A_T1LOW]);
   wire lowRd = lowWr | (lvl1 & permB[pga_pkg::PGA_B_T1LOW]);
   wire midWr = lvl2 | (lvl1 & permA[pga_pkg::PGA_A_T1MID]);
   wire midRd = midWr | (lvl1 & permB[pga_pkg::PGA_B_T1MID]);
   wire lwrWr = lvl2 | (lvl1 & permA[pga_pkg::PGA_A_LOWER]);
   wire auxLoWr = lvl2 | (lvl1 & permA[pga_pkg::PGA_A_AUXLO])
                  | permB[pga_pkg::PGA_B_AUXLO];
   wire auxHiWr = lvl2 | (lvl1 & permA[pga_pkg::PGA_A_AUXHI])
                  | permB[pga_pkg::PGA_B_AUXHI];

   // ************************************************************
   // verdict; unlisted tables stay level-2 only, bytes 60h-7Fh are open
   // ************************************************************
   assign verdict.readOk = inAux   ? 1'b1 :
                           inLower ? 1'b1 :
                           ~inTable ? 1'b1 :
                           inKey1  ? 1'b0 :
                           inCfg   ? cfgRd :
                           inTop   ? topRd :
                           inT1Low ? lowRd :
                           inT1Mid ? midRd :
                           inT46   ? t46 :
                           inT78   ? t78 : lvl2;
   assign verdict.writeOk = inAux   ? (auxHigh ? auxHiWr : auxLoWr) :
                            inLower ? lwrWr :
                            ~inTable ? 1'b1 :
                            inKey1  ? keyWr :
                            inCfg   ? cfgWr :
                            inTop   ? topWr :
                            inT1Low ? lowWr :
                            inT1Mid ? midWr :
                            inT46   ? t46 :
                            inT78   ? t78 : lvl2;
endmodule
`default_nettype wire

/* rtl/pga_perm_regs.sv */
// pga_perm_regs: the two permission bytes, loaded to their defaults at reset.
// assumes: the caller only raises a write strobe for an already granted write.
`timescale 1ns/1ps
`default_nettype none
module pga_perm_regs (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       writeA,
   input  wire logic       writeB,
   input  wire logic [7:0] wdata,
   input  wire logic       levelTwo,
   output logic [7:0]      permA,
   output logic [7:0]      permB
);
   // a level-1 holder may rewrite the first byte but not its own grant bit
   localparam logic [7:0] CFG_BIT = 8'h01 << pga_pkg::PGA_A_CFG;
   wire [7:0] keepMask = levelTwo ? pga_pkg::PGA_ZERO_BYTE : CFG_BIT;
   wire [7:0] next_permA = (permA & keepMask) | (wdata & ~keepMask);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         permA <= pga_pkg::PGA_RST_PERM_A;
         permB <= pga_pkg::PGA_RST_PERM_B;
      end else begin
         if (writeA) begin
            permA <= next_permA;
         end
         if (writeB) begin
            permB <= wdata;
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/pga_gate.sv */
// pga_gate: password access gate for the management memory map.
// assumes: one clock, synchronous active-low reset, a serial engine that
// presents one memory access at a time with the holder's password level,
// and software on a plain register port that also states its level.
//
// Overview of operation
// - config table readable by level2, or granted level1
// - config table writable by level2, or rw-granted level1
// - tables 07h/08h shared with level1 when bit set
// - selected top bytes F8h-FFh shared when bit set
// - level1 config rw grant; only level2 changes it
// - table 01h 80h-BFh shared by default
// - table 01h C0h-F7h shared when bit set
// - lower main memory writes shared when bit set
// - auxiliary halves writes shared with level1 when set
// - tables 04h/06h shared with level1 when set
// - level1 may read selected top bytes when set
// - level1 may read config table when set
// - level1 may read table 01h ranges when set
// - level1 key never readable; write needs grant
// - auxiliary halves writable by anyone when set
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pga_gate #(
   parameter int CNT_W = 8
) (
   input  wire logic                clk,
   input  wire logic                rstn,
   // register port
   input  wire logic [7:0]          regAddr,
   input  wire logic [7:0]          regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   input  wire pga_pkg::pga_level_t regLevel,
   output logic [7:0]               regRdata,
   // memory access check
   input  wire logic                tableMask,
   input  wire logic                reqValid,
   input  wire pga_pkg::pga_req_t   req,
   input  wire pga_pkg::pga_level_t reqLevel,
   output logic                     ansValid,
   output logic                     ansGrant,
   output logic                     memWrite,
   output logic                     memRead,
   output pga_pkg::pga_req_t        memReq
);

   // ************************************************************
   // permission storage and the two verdict decoders
   // ************************************************************
   logic [7:0]            permA;
   logic [7:0]            permB;
   pga_pkg::pga_verdict_t reqVerdict;
   pga_pkg::pga_verdict_t regVerdict;
   pga_pkg::pga_req_t     regAsReq;

   // the register port lands in the config table, so it is checked as such
   assign regAsReq.write     = regWr;
   assign regAsReq.region    = pga_pkg::PGA_RGN_MAIN;
   assign regAsReq.table_num = pga_pkg::PGA_TBL_CFG;
   assign regAsReq.addr      = regAddr;

   pga_decide u_req_decide (
      .permA     (permA),
      .permB     (permB),
      .level     (reqLevel),
      .tableMask (tableMask),
      .req       (req),
      .verdict   (reqVerdict)
   );

   pga_decide u_reg_decide (
      .permA     (permA),
      .permB     (permB),
      .level     (regLevel),
      .tableMask (tableMask),
      .req       (regAsReq),
      .verdict   (regVerdict)
   );

   // ************************************************************
   // register port decode
   // ************************************************************
   wire selPermA   = (regAddr == pga_pkg::PGA_OFF_PERM_A);
   wire selPermB   = (regAddr == pga_pkg::PGA_OFF_PERM_B);
   wire selStatus  = (regAddr == pga_pkg::PGA_OFF_STATUS);
   wire selDenRd   = (regAddr == pga_pkg::PGA_OFF_DEN_RD);
   wire selDenWr   = (regAddr == pga_pkg::PGA_OFF_DEN_WR);
   wire selLastAdr = (regAddr == pga_pkg::PGA_OFF_LAST_ADR);
   wire selLastTbl = (regAddr == pga_pkg::PGA_OFF_LAST_TBL);
   wire selPerm    = selPermA | selPermB;

   // permission bytes are config-table bytes: both directions are checked
   wire permWrOk = regWr & selPerm & regVerdict.writeOk;
   wire permRdOk = regRd & selPerm & regVerdict.readOk;
   wire permWrNo = regWr & selPerm & ~regVerdict.writeOk;
   wire permRdNo = regRd & selPerm & ~regVerdict.readOk;
   wire levelTwo = (regLevel == pga_pkg::PGA_LVL_TWO);

   pga_perm_regs u_perm (
      .clk      (clk),
      .rstn     (rstn),
      .writeA   (permWrOk & selPermA),
      .writeB   (permWrOk & selPermB),
      .wdata    (regWdata),
      .levelTwo (levelTwo),
      .permA    (permA),
      .permB    (permB)
   );

   // ************************************************************
   // memory access verdict
   // ************************************************************
   wire reqOk  = req.write ? reqVerdict.writeOk : reqVerdict.readOk;
   wire reqNo  = reqValid & ~reqOk;
   wire rdDeny = (reqNo & ~req.write) | permRdNo;
   wire wrDeny = (reqNo & req.write) | permWrNo;

   logic                     next_ansValid;
   logic                     next_ansGrant;
   logic                     next_memWrite;
   logic                     next_memRead;

   assign next_ansValid = reqValid;
   assign next_ansGrant = reqValid & reqOk;
   // the strobe to memory is the only path a write can take, so a refused
   // write simply never produces it
   assign next_memWrite = reqValid & reqOk & req.write;
   assign next_memRead  = reqValid & reqOk & ~req.write;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ansValid <= 1'b0;
         ansGrant <= 1'b0;
         memWrite <= 1'b0;
         memRead  <= 1'b0;
      end else begin
         ansValid <= next_ansValid;
         ansGrant <= next_ansGrant;
         memWrite <= next_memWrite;
         memRead  <= next_memRead;
      end
   end

   // address and table are held with the strobe so memory sees a stable pair
   always_ff @(posedge clk) begin
      if (!rstn) begin
         memReq <= '0;
      end else if (reqValid) begin
         memReq <= req;
      end
   end

   // ************************************************************
   // denial bookkeeping
   // ************************************************************
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
   localparam logic [CNT_W-1:0] CNT_MAX  = '1;

   logic [CNT_W-1:0] denRdCnt;
   logic [CNT_W-1:0] denWrCnt;
   logic [7:0]       lastAdr;
   logic [7:0]       lastTbl;
   logic             lastWasWrite;
   logic             lastWasAux;
   logic             anyDenied;

   // a write to a counter clears it; a denial in that same cycle still counts
   wire clrDenRd = regWr & selDenRd;
   wire clrDenWr = regWr & selDenWr;
   wire [CNT_W-1:0] incDenRd = (denRdCnt == CNT_MAX) ? denRdCnt : denRdCnt + CNT_ONE;
   wire [CNT_W-1:0] incDenWr = (denWrCnt == CNT_MAX) ? denWrCnt : denWrCnt + CNT_ONE;
   wire [CNT_W-1:0] next_denRdCnt = clrDenRd ? (rdDeny ? CNT_ONE : CNT_ZERO) :
                                    rdDeny   ? incDenRd : denRdCnt;
   wire [CNT_W-1:0] next_denWrCnt = clrDenWr ? (wrDeny ? CNT_ONE : CNT_ZERO) :
                                    wrDeny   ? incDenWr : denWrCnt;

   // a refused memory access outranks a refused register access for capture
   wire [7:0] next_lastAdr = reqNo ? req.addr : regAddr;
   wire [7:0] next_lastTbl = reqNo ? req.table_num : pga_pkg::PGA_TBL_CFG;
   wire       next_lastWr  = reqNo ? req.write : permWrNo;
   wire       next_lastAux = reqNo & (req.region == pga_pkg::PGA_RGN_AUX);
   wire       capture      = reqNo | permWrNo | permRdNo;
   wire       clrAny       = regWr & selStatus;
   wire       next_anyDen  = capture | (anyDenied & ~clrAny);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         denRdCnt <= CNT_ZERO;
         denWrCnt <= CNT_ZERO;
      end else begin
         denRdCnt <= next_denRdCnt;
         denWrCnt <= next_denWrCnt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         lastAdr      <= pga_pkg::PGA_ZERO_BYTE;
         lastTbl      <= pga_pkg::PGA_ZERO_BYTE;
         lastWasWrite <= 1'b0;
         lastWasAux   <= 1'b0;
      end else if (capture) begin
         lastAdr      <= next_lastAdr;
         lastTbl      <= next_lastTbl;
         lastWasWrite <= next_lastWr;
         lastWasAux   <= next_lastAux;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         anyDenied <= 1'b0;
      end else begin
         anyDenied <= next_anyDen;
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   // status: [0] sticky denial, [1] last denial was a write, [2] it was aux,
   // [3] current port level is two, [4] table mask as seen now
   wire [7:0] statusByte = {3'h0, tableMask, levelTwo, lastWasAux, lastWasWrite, anyDenied};
   wire [7:0] cntRdByte  = 8'(denRdCnt);
   wire [7:0] cntWrByte  = 8'(denWrCnt);

   // a refused read of a permission byte returns zero, never the content
   wire [7:0] next_regRdata = !regRd     ? pga_pkg::PGA_ZERO_BYTE :
                              permRdOk & selPermA ? permA :
                              permRdOk & selPermB ? permB :
                              selStatus  ? statusByte :
                              selDenRd   ? cntRdByte :
                              selDenWr   ? cntWrByte :
                              selLastAdr ? lastAdr :
                              selLastTbl ? lastTbl : pga_pkg::PGA_ZERO_BYTE;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         regRdata <= pga_pkg::PGA_ZERO_BYTE;
      end else begin
         regRdata <= next_regRdata;
      end
   end

endmodule
`default_nettype wire

/* verif/pga_gate_props.sv */
// pga_gate_props: port-level properties of the access gate.
// assumes: bound into every pga_gate; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pga_gate_props #(
   parameter int CNT_W = 8
) (
   input wire logic                clk,
   input wire logic                rstn,
   input wire logic [7:0]          regAddr,
   input wire logic [7:0]          regWdata,
   input wire logic                regWr,
   input wire logic                regRd,
   input wire pga_pkg::pga_level_t regLevel,
   input wire logic [7:0]          regRdata,
   input wire logic                tableMask,
   input wire logic                reqValid,
   input wire pga_pkg::pga_req_t   req,
   input wire pga_pkg::pga_level_t reqLevel,
   input wire logic                ansValid,
   input wire logic                ansGrant,
   input wire logic                memWrite,
   input wire logic                memRead,
   input wire pga_pkg::pga_req_t   memReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // upper half of main memory is where the numbered tables live
   wire tblReq = req.region == pga_pkg::PGA_RGN_MAIN && req.addr >= 8'h80;
   wire keyRd  = tblReq && !req.write && req.table_num == 8'h02 && req.addr[7:2] == 6'h2C;

   chk_ans_follows: assert property (reqValid |=> ansValid)
      else $error("access not answered one cycle later");
   chk_no_stray: assert property (!reqValid |=> !ansValid && !memWrite && !memRead)
      else $error("answer or strobe without a request");
   chk_grant_strobe: assert property (ansValid |-> ansGrant == (memWrite || memRead)
      && !(memWrite && memRead))
      else $error("grant and memory strobes disagree");
   chk_strobe_kind: assert property ((memWrite || memRead) |-> memWrite == memReq.write)
      else $error("memory strobe of the wrong kind");
   chk_req_copied: assert property (reqValid |=> memReq == $past(req))
      else $error("forwarded request differs from the one taken");
   chk_key_hidden: assert property (reqValid && keyRd |=> ansValid && !memRead)
      else $error("level one key bytes were readable");
   chk_open_reads: assert property (reqValid && !req.write
      && (req.region == pga_pkg::PGA_RGN_AUX || req.addr <= 8'h5F) |=> memRead)
      else $error("open read area refused");
   chk_level_two: assert property (reqValid && reqLevel == pga_pkg::PGA_LVL_TWO && !keyRd
      |=> ansGrant)
      else $error("level two access refused");
   chk_anon_tables: assert property (reqValid && reqLevel == pga_pkg::PGA_LVL_NONE && tblReq
      |=> !ansGrant)
      else $error("table access granted without a password");
   chk_perm_hidden: assert property (regRd && regLevel == pga_pkg::PGA_LVL_NONE
      && regAddr[7:1] == 7'h60 |=> regRdata == 8'h00)
      else $error("permission byte read without a password");

   cover property (reqValid ##1 memWrite);
   cover property (reqValid ##1 ansValid && !ansGrant);
   cover property (regRd ##1 regRdata != 8'h00);
endmodule

bind pga_gate pga_gate_props #(.CNT_W(CNT_W)) i_pga_gate_props (
   .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .regLevel(regLevel), .regRdata(regRdata), .tableMask(tableMask),
   .reqValid(reqValid), .req(req), .reqLevel(reqLevel), .ansValid(ansValid),
   .ansGrant(ansGrant), .memWrite(memWrite), .memRead(memRead), .memReq(memReq));
`default_nettype wire

/* verif/pga_host.sv */
// pga_host: management host model, one memory access per call.
// assumes: clk is the gate's clock; the bench calls access from one process.
`timescale 1ns/1ps
`default_nettype none
module pga_host (
   input  wire logic           clk,
   output logic                reqValid,
   output pga_pkg::pga_req_t   req,
   output pga_pkg::pga_level_t reqLevel
);
   initial reqValid = 1'h0;
   initial req = '0;
   initial reqLevel = pga_pkg::PGA_LVL_NONE;
   task automatic access(input pga_pkg::pga_req_t r, input pga_pkg::pga_level_t l);
      @(posedge clk);
      reqValid <= 1'h1;
      req      <= r;
      reqLevel <= l;
      @(posedge clk);
      reqValid <= 1'h0;
      // released fields scramble so nothing leans on stale values
      req      <= ~r;
   endtask
endmodule
`default_nettype wire

/* verif/test_pga_gate.sv */
// test_pga_gate: directed checks of the access gate and its permission bytes.
// assumes: pga_host plays the management host; the bench owns the register port.
`timescale 1ns/1ps
`default_nettype none
module test_pga_gate;
   localparam pga_pkg::pga_level_t L0 = pga_pkg::PGA_LVL_NONE;
   localparam pga_pkg::pga_level_t L1 = pga_pkg::PGA_LVL_ONE;
   localparam pga_pkg::pga_level_t L2 = pga_pkg::PGA_LVL_TWO;
   // access kinds: bit 0 write, bit 1 auxiliary memory
   localparam logic [1:0] RM = 2'h0, WM = 2'h1, WA = 2'h3;
   logic                clk = 1'h0, rstn = 1'h0;
   logic                regWr = 1'h0, regRd = 1'h0, tableMask = 1'h0;
   logic [7:0]          regAddr = 8'h00, regWdata = 8'h00, regRdata;
   pga_pkg::pga_level_t regLevel = L0;
   pga_pkg::pga_level_t reqLevel;
   pga_pkg::pga_req_t   req, memReq;
   logic                reqValid, ansValid, ansGrant, memWrite, memRead;
   int                  mismatches = 0, nTests = 0;
   always #20 clk = ~clk;
   pga_host i_pga_host (.clk(clk), .reqValid(reqValid), .req(req), .reqLevel(reqLevel));
   pga_gate #(.CNT_W(8)) i_pga_gate (
      .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regLevel(regLevel), .regRdata(regRdata), .tableMask(tableMask),
      .reqValid(reqValid), .req(req), .reqLevel(reqLevel), .ansValid(ansValid),
      .ansGrant(ansGrant), .memWrite(memWrite), .memRead(memRead), .memReq(memReq));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      nTests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // register port: a read compares the returned byte with d
   task automatic rp(input logic w, input logic [7:0] a, d, input pga_pkg::pga_level_t l);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regLevel <= l;
      regWr    <= w;
      regRd    <= !w;
      @(posedge clk);
      regWr    <= 1'h0;
      regRd    <= 1'h0;
      #1 if (!w) chk(regRdata, d);
   endtask
   task automatic acc(input logic [1:0] k, input logic [7:0] t, a,
         input pga_pkg::pga_level_t l, input logic g);
      i_pga_host.access({k[0], k[1], t, a}, l);
      #1 chk({4'h0, ansValid, ansGrant, memWrite, memRead}, {5'h01, g, g & k[0], g & !k[0]});
      chk(memReq.addr, a);
      chk(memReq.table_num, t);
   endtask
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'h1;
      rp(1'h0, 8'hC0, 8'h10, L2);
      rp(1'h0, 8'hC1, 8'h03, L2);
      rp(1'h0, 8'hC0, 8'h00, L1);
      rp(1'h0, 8'h50, 8'h00, L2);
      rp(1'h1, 8'hC1, 8'hFC, L1);
      rp(1'h0, 8'hC1, 8'h03, L2);
      acc(RM, 8'h02, 8'h90, L1, 1'h0);
      acc(RM, 8'h02, 8'hB1, L2, 1'h0);
      acc(WA, 8'h00, 8'h90, L0, 1'h1);
      acc(RM, 8'h01, 8'h90, L1, 1'h1);
      acc(WM, 8'h01, 8'hC0, L1, 1'h0);
      acc(WM, 8'h00, 8'h10, L1, 1'h0);
      acc(WM, 8'h07, 8'h80, L1, 1'h0);
      acc(RM, 8'h04, 8'h80, L1, 1'h0);
      acc(RM, 8'h01, 8'hF8, L1, 1'h0);
      rp(1'h1, 8'hC1, 8'hFC, L2);
      acc(RM, 8'h02, 8'hA0, L1, 1'h1);
      acc(WM, 8'h02, 8'hA0, L1, 1'h0);
      acc(WM, 8'h06, 8'h80, L1, 1'h1);
      acc(RM, 8'h01, 8'hFF, L1, 1'h1);
      acc(RM, 8'h01, 8'hF7, L1, 1'h1);
      acc(WM, 8'h02, 8'hB3, L1, 1'h1);
      acc(WA, 8'h00, 8'h80, L0, 1'h0);
      rp(1'h1, 8'hC0, 8'hFF, L2);
      acc(WA, 8'h00, 8'h7F, L1, 1'h1);
      acc(WM, 8'h08, 8'hFF, L1, 1'h1);
      acc(WM, 8'h00, 8'h5F, L1, 1'h1);
      acc(WM, 8'h01, 8'hF8, L1, 1'h1);
      @(posedge clk);
      tableMask <= 1'h1;
      acc(WM, 8'h01, 8'hF8, L1, 1'h0);
      acc(WM, 8'h05, 8'hFF, L1, 1'h1);
      // level one may write the byte but never move its own config grant
      rp(1'h1, 8'hC0, 8'h00, L1);
      rp(1'h0, 8'hC0, 8'h20, L2);
      acc(WM, 8'h02, 8'h90, L2, 1'h1);
      rp(1'h0, 8'hC1, 8'h00, L0);
      acc(RM, 8'h01, 8'h90, L0, 1'h0);
      // seven refused reads and seven refused writes so far, last one a table read
      rp(1'h0, 8'hD1, 8'h07, L2);
      rp(1'h0, 8'hD2, 8'h07, L2);
      rp(1'h0, 8'hD3, 8'h90, L2);
      rp(1'h0, 8'hD4, 8'h01, L2);
      rp(1'h0, 8'hD0, 8'h19, L2);
      rp(1'h1, 8'hD2, 8'h00, L2);
      rp(1'h0, 8'hD2, 8'h00, L2);
      rp(1'h1, 8'hD0, 8'h00, L2);
      rp(1'h0, 8'hD0, 8'h18, L2);
      print_verdict;
   end
endmodule
`default_nettype wire
